// File: core/tppio_pkg.sv
// tppio_pkg: register map, field positions and reset values of the
// three-port parallel i/o block.
// assumes a byte-wide register port on the 20 MHz system clock.
package tppio_pkg;
  localparam int unsigned PORT_W      = 8;
  localparam int unsigned ADDR_W      = 8;
  // register offsets (printed ones first, the rest chosen)
  localparam logic [7:0] OFF_PA_LATCH = 8'h00;
  localparam logic [7:0] OFF_PB_LATCH = 8'h01;
  localparam logic [7:0] OFF_PC_LATCH = 8'h02;
  localparam logic [7:0] OFF_PA_DIR   = 8'h04;
  localparam logic [7:0] OFF_PB_DIR   = 8'h05;
  localparam logic [7:0] OFF_PC_DIR   = 8'h06;
  localparam logic [7:0] OFF_PA_LED   = 8'h0C;
  // reset values
  localparam logic [7:0] DIR_RST      = 8'h00;
  localparam logic [7:0] LED_RST      = 8'h00;
  localparam logic [7:0] RD_UNMAPPED  = 8'h00;
  // adc channel-select codes that name a port a pin (0..7)
  localparam logic [4:0] ADC_PIN_MAX  = 5'h07;
  // port b field positions
  localparam int unsigned PB_SDA      = 0;
  localparam int unsigned PB_SCL      = 1;
  localparam int unsigned PB_TXD      = 2;
  localparam int unsigned PB_RXD      = 3;
  localparam logic [7:0] PB_OD_MASK   = 8'h0F;
  // port c field positions, then port c and port b peripheral masks and the timer edge/level port code
  localparam int unsigned PC_IRQ      = 0;
  localparam int unsigned PC_MISO     = 2;
  localparam int unsigned PC_MOSI     = 3;
  localparam int unsigned PC_SS       = 4;
  localparam int unsigned PC_SCK      = 5;
  localparam int unsigned PC_IR_TXD   = 6;
  localparam int unsigned PC_IR_RXD   = 7;
  localparam logic [7:0] PC_SPI_MASK  = 8'h3C;
  localparam logic [7:0] PC_IR_MASK   = 8'hC0;
  localparam logic [7:0] PB_TWI_MASK  = 8'h03;
  localparam logic [7:0] PB_SCI_MASK  = 8'h0C;
  localparam logic [1:0] ELS_PORT     = 2'h0;
endpackage : tppio_pkg

// File: core/tppio_top.sv
// tppio_top: data latches and direction registers of ports a, b and c,
// the port a led-sink register, and pin read-back and peripheral take-over muxes.
// assumes pin inputs are asynchronous; peripheral enables and outputs come
// from logic on the same clock. open-drain resolution lives outside.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - direction one drives the latch onto the pin; zero leaves pin hi-z input
// - reset clears all direction bits of every port, pins become inputs
// - port a read returns latch for bits set as outputs
// - port a read returns sampled pin level for bits set as inputs
// - port b read selects latch or pin per direction bit likewise
// - data latch writes always land, whatever direction holds
// - reset leaves data latches untouched
// - eight led-enable bits, read/write; one selects strong sink drive on an output pin
// - port b bits 3..0 are open drain: pull low or release
// - two-wire enable hands port b bits 0,1 to that module
// - serial enable hands port b bits 2,3 to transmit and receive
// - timer edge/level select claims port b bits 4..7 as channel pins
// - port c bit 0 always feeds the second external interrupt
// - port c bit 0 pull-up is off when pull-up disable is set
// - spi enable claims port c bits 2..5 as miso, mosi, ss, sck
// - infrared serial enable claims port c bits 6,7 as transmit, receive
// - each port has eight data latches and eight direction bits
// - adc channel select claims the chosen port a pin as analog
// - port c read selects latch or pin per direction bit
module tppio_top
  import tppio_pkg::*;
(
  input  wire logic                        core_clk_i,
  input  wire logic                        rst_i,
  // register port
  input  wire logic [tppio_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [tppio_pkg::PORT_W-1:0] reg_wdata_i,
  input  wire logic                        reg_wr_i,
  input  wire logic                        reg_rd_i,
  output logic      [tppio_pkg::PORT_W-1:0] reg_rdata_o,
  // pins
  input  wire logic [tppio_pkg::PORT_W-1:0] port_a_pin_i,
  output logic      [tppio_pkg::PORT_W-1:0] port_a_pin_o,
  output logic      [tppio_pkg::PORT_W-1:0] port_a_pin_oe_o,
  output logic      [tppio_pkg::PORT_W-1:0] port_a_strong_sink_o,
  output logic      [tppio_pkg::PORT_W-1:0] port_a_analog_o,
  input  wire logic [tppio_pkg::PORT_W-1:0] port_b_pin_i,
  output logic      [tppio_pkg::PORT_W-1:0] port_b_pin_o,
  output logic      [tppio_pkg::PORT_W-1:0] port_b_pin_oe_o,
  input  wire logic [tppio_pkg::PORT_W-1:0] port_c_pin_i,
  output logic      [tppio_pkg::PORT_W-1:0] port_c_pin_o,
  output logic      [tppio_pkg::PORT_W-1:0] port_c_pin_oe_o,
  output logic                             port_c0_pullup_en_o,
  // peripheral controls
  input  wire logic                        adc_enable_i,
  input  wire logic [4:0]                  adc_channel_select_i,
  input  wire logic                        two_wire_module_enable_i,
  input  wire logic                        two_wire_sda_low_i,
  input  wire logic                        two_wire_scl_low_i,
  input  wire logic                        serial_unit_enable_i,
  input  wire logic                        serial_txd_i,
  input  wire logic [1:0]                  timer_one_ch0_els_i,
  input  wire logic [1:0]                  timer_one_ch1_els_i,
  input  wire logic [1:0]                  timer_two_ch0_els_i,
  input  wire logic [1:0]                  timer_two_ch1_els_i,
  input  wire logic [3:0]                  timer_ch_out_i,
  input  wire logic [3:0]                  timer_ch_oe_i,
  input  wire logic                        port_c0_pullup_disable_i,
  input  wire logic                        spi_unit_enable_i,
  input  wire logic [3:0]                  spi_out_i,
  input  wire logic [3:0]                  spi_oe_i,
  input  wire logic                        infrared_serial_unit_enable_i,
  input  wire logic                        infrared_serial_transmit_i,
  // synchronised pin levels back to the peripherals
  output logic      [tppio_pkg::PORT_W-1:0] port_b_sync_o,
  output logic      [tppio_pkg::PORT_W-1:0] port_c_sync_o,
  output logic                             second_external_interrupt_o
);
  import tppio_pkg::*;

  // eight latches and directions per port
  logic [PORT_W-1:0] pa_latch_reg, pb_latch_reg, pc_latch_reg;
  logic [PORT_W-1:0] pa_dir_reg, pb_dir_reg, pc_dir_reg;
  logic [PORT_W-1:0] pa_led_reg;
  logic [PORT_W-1:0] rdata_reg;
  logic [PORT_W-1:0] pa_s1_reg, pa_s2_reg, pa_s3_reg, pa_lvl_reg;
  logic [PORT_W-1:0] pb_s1_reg, pb_s2_reg, pb_s3_reg, pb_lvl_reg;
  logic [PORT_W-1:0] pc_s1_reg, pc_s2_reg, pc_s3_reg, pc_lvl_reg;
  logic [PORT_W-1:0] pa_read, pb_read, pc_read;
  logic [PORT_W-1:0] rdata_next;
  logic [PORT_W-1:0] adc_claim;
  logic [3:0]        timer_claim;

  // pin synchronisers: three stages, level accepted once stages 2 and 3 agree
  always_ff @(posedge core_clk_i) begin
    pa_s1_reg <= port_a_pin_i;
    pa_s2_reg <= pa_s1_reg;
    pa_s3_reg <= pa_s2_reg;
    pb_s1_reg <= port_b_pin_i;
    pb_s2_reg <= pb_s1_reg;
    pb_s3_reg <= pb_s2_reg;
    pc_s1_reg <= port_c_pin_i;
    pc_s2_reg <= pc_s1_reg;
    pc_s3_reg <= pc_s2_reg;
  end

  // accepted levels hold until two stages agree, filtering one-cycle glitches
  genvar gi;
  generate
    for (gi = 0; gi < PORT_W; gi++) begin : g_filt
      always_ff @(posedge core_clk_i) begin
        if (pa_s2_reg[gi] == pa_s3_reg[gi]) begin
          pa_lvl_reg[gi] <= pa_s3_reg[gi];
        end
        if (pb_s2_reg[gi] == pb_s3_reg[gi]) begin
          pb_lvl_reg[gi] <= pb_s3_reg[gi];
        end
        if (pc_s2_reg[gi] == pc_s3_reg[gi]) begin
          pc_lvl_reg[gi] <= pc_s3_reg[gi];
        end
      end
    end
  endgenerate

  // no reset term: latches keep their value through reset
  // captured on the edge of the write cycle
  always_ff @(posedge core_clk_i) begin
    if (reg_wr_i) begin
      if (reg_addr_i == OFF_PA_LATCH) begin
        pa_latch_reg <= reg_wdata_i;
      end else if (reg_addr_i == OFF_PB_LATCH) begin
        pb_latch_reg <= reg_wdata_i;
      end else if (reg_addr_i == OFF_PC_LATCH) begin
        pc_latch_reg <= reg_wdata_i;
      end
    end
  end

  // led enables read/write, cleared on reset
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pa_dir_reg <= DIR_RST;
      pb_dir_reg <= DIR_RST;
      pc_dir_reg <= DIR_RST;
      pa_led_reg <= LED_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == OFF_PA_DIR) begin
        pa_dir_reg <= reg_wdata_i;
      end else if (reg_addr_i == OFF_PB_DIR) begin
        pb_dir_reg <= reg_wdata_i;
      end else if (reg_addr_i == OFF_PC_DIR) begin
        pc_dir_reg <= reg_wdata_i;
      end else if (reg_addr_i == OFF_PA_LED) begin
        pa_led_reg <= reg_wdata_i;
      end
    end
  end

  // latch for outputs, pin for inputs
  always_comb begin
    pa_read = (pa_dir_reg & pa_latch_reg) | (~pa_dir_reg & pa_lvl_reg);
    pb_read = (pb_dir_reg & pb_latch_reg) | (~pb_dir_reg & pb_lvl_reg);
    pc_read = (pc_dir_reg & pc_latch_reg) | (~pc_dir_reg & pc_lvl_reg);
  end

  // read decode; unmapped addresses answer zero
  always_comb begin
    rdata_next = RD_UNMAPPED;
    if (reg_addr_i == OFF_PA_LATCH) begin
      rdata_next = pa_read;
    end else if (reg_addr_i == OFF_PB_LATCH) begin
      rdata_next = pb_read;
    end else if (reg_addr_i == OFF_PC_LATCH) begin
      rdata_next = pc_read;
    end else if (reg_addr_i == OFF_PA_DIR) begin
      rdata_next = pa_dir_reg;
    end else if (reg_addr_i == OFF_PB_DIR) begin
      rdata_next = pb_dir_reg;
    end else if (reg_addr_i == OFF_PC_DIR) begin
      rdata_next = pc_dir_reg;
    end else if (reg_addr_i == OFF_PA_LED) begin
      rdata_next = pa_led_reg;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_reg <= RD_UNMAPPED;
    end else if (reg_rd_i) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= RD_UNMAPPED;
    end
  end
  assign reg_rdata_o = rdata_reg;

  // adc claims the selected port a pin when enabled
  always_comb begin
    adc_claim = '0;
    if (adc_enable_i && (adc_channel_select_i <= ADC_PIN_MAX)) begin
      adc_claim[adc_channel_select_i[2:0]] = 1'b1;
    end
  end

  // port a driver follows direction, analog pin released
  // strong sink only on output pins
  always_comb begin
    port_a_pin_o         = pa_latch_reg;
    port_a_pin_oe_o      = pa_dir_reg & ~adc_claim;
    port_a_strong_sink_o = pa_led_reg & pa_dir_reg & ~adc_claim;
    port_a_analog_o      = adc_claim;
  end

  // any non-zero edge/level select gives the pin to its timer
  always_comb begin
    timer_claim[0] = (timer_one_ch0_els_i != ELS_PORT);
    timer_claim[1] = (timer_one_ch1_els_i != ELS_PORT);
    timer_claim[2] = (timer_two_ch0_els_i != ELS_PORT);
    timer_claim[3] = (timer_two_ch1_els_i != ELS_PORT);
  end

  // port b mux; bits 3..0 open drain, so they only ever drive low
  always_comb begin
    logic [PORT_W-1:0] want_low;
    want_low        = '0;
    port_b_pin_o    = pb_latch_reg;
    port_b_pin_oe_o = pb_dir_reg;
    // two-wire module owns sda and scl
    if (two_wire_module_enable_i) begin
      port_b_pin_o[PB_SDA]    = ~two_wire_sda_low_i;
      port_b_pin_oe_o[PB_SDA] = 1'b1;
      port_b_pin_o[PB_SCL]    = ~two_wire_scl_low_i;
      port_b_pin_oe_o[PB_SCL] = 1'b1;
    end
    // serial unit transmits on bit 2, receive bit 3 is input
    if (serial_unit_enable_i) begin
      port_b_pin_o[PB_TXD]    = serial_txd_i;
      port_b_pin_oe_o[PB_TXD] = 1'b1;
      port_b_pin_oe_o[PB_RXD] = 1'b0;
    end
    for (int i = 0; i < 4; i++) begin
      if (timer_claim[i]) begin
        port_b_pin_o[i+4]    = timer_ch_out_i[i];
        port_b_pin_oe_o[i+4] = timer_ch_oe_i[i];
      end
    end
    // open drain: enable only while pulling low, drive value zero
    want_low        = port_b_pin_oe_o & ~port_b_pin_o;
    port_b_pin_oe_o = (port_b_pin_oe_o & ~PB_OD_MASK) | (want_low & PB_OD_MASK);
    port_b_pin_o    = port_b_pin_o & ~PB_OD_MASK;
  end

  // port c mux
  always_comb begin
    port_c_pin_o    = pc_latch_reg;
    port_c_pin_oe_o = pc_dir_reg;
    if (spi_unit_enable_i) begin
      port_c_pin_o[PC_SCK:PC_MISO]    = spi_out_i;
      port_c_pin_oe_o[PC_SCK:PC_MISO] = spi_oe_i;
    end
    if (infrared_serial_unit_enable_i) begin
      port_c_pin_o[PC_IR_TXD]    = infrared_serial_transmit_i;
      port_c_pin_oe_o[PC_IR_TXD] = 1'b1;
      port_c_pin_o[PC_IR_RXD]    = 1'b0;
      port_c_pin_oe_o[PC_IR_RXD] = 1'b0;
    end
  end

  assign port_c0_pullup_en_o = ~port_c0_pullup_disable_i;

  // pin level always reaches the interrupt, even as plain i/o
  assign second_external_interrupt_o = pc_lvl_reg[PC_IRQ];
  assign port_b_sync_o = pb_lvl_reg;
  assign port_c_sync_o = pc_lvl_reg;

endmodule : tppio_top

`default_nettype wire

// File: tb/tppio_sva.sv
// tppio_sva: port-level checks of the three-port parallel i/o block.
// assumes it is bound to tppio_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module tppio_sva
  import tppio_pkg::*;
(
  input wire logic       core_clk_i,
  input wire logic       rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [7:0] port_a_pin_o,
  input wire logic [7:0] port_a_pin_oe_o,
  input wire logic [7:0] port_a_strong_sink_o,
  input wire logic [7:0] port_a_analog_o,
  input wire logic       adc_enable_i,
  input wire logic [4:0] adc_channel_select_i,
  input wire logic [7:0] port_b_pin_o,
  input wire logic [7:0] port_c_pin_i,
  input wire logic [7:0] port_c_pin_oe_o,
  input wire logic       spi_unit_enable_i,
  input wire logic [3:0] spi_oe_i,
  input wire logic       second_external_interrupt_o
);
  // all checks sit on the one system clock
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_reset_dir_clear: assert property (disable iff (1'b0)
    rst_i |=> port_a_pin_oe_o == 8'h00 && port_a_strong_sink_o == 8'h00)
    else $error("pins not inputs after reset");
  a_dir_write_a: assert property (
    reg_wr_i && reg_addr_i == OFF_PA_DIR |=> adc_enable_i || port_a_pin_oe_o == $past(reg_wdata_i))
    else $error("direction write not on drive enables");
  a_latch_write_a: assert property (
    reg_wr_i && reg_addr_i == OFF_PA_LATCH |=> port_a_pin_o == $past(reg_wdata_i))
    else $error("latch write not on pins");
  a_read_latch_a: assert property (
    reg_rd_i && reg_addr_i == OFF_PA_LATCH && port_a_pin_oe_o == 8'hFF
    |=> reg_rdata_o == $past(port_a_pin_o)) else $error("output read not latch");
  a_led_on_output: assert property (
    (port_a_strong_sink_o & ~port_a_pin_oe_o) == 8'h00) else $error("sink on input pin");
  a_adc_claim_pin: assert property (
    adc_enable_i && adc_channel_select_i <= ADC_PIN_MAX |-> port_a_analog_o ==
    8'h01 << adc_channel_select_i && !port_a_pin_oe_o[adc_channel_select_i[2:0]])
    else $error("analog claim wrong");
  a_open_drain_b: assert property (
    port_b_pin_o[3:0] == 4'h0) else $error("open drain bit driven high");
  a_spi_owns_c: assert property (
    spi_unit_enable_i |-> port_c_pin_oe_o[5:2] == spi_oe_i) else $error("spi enables wrong");
  a_irq_follow_pin: assert property (
    port_c_pin_i[0] [*6] |-> second_external_interrupt_o) else $error("interrupt input lost");
endmodule : tppio_sva

bind tppio_top tppio_sva i_tppio_sva (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .port_a_pin_o(port_a_pin_o),
  .port_a_pin_oe_o(port_a_pin_oe_o), .port_a_strong_sink_o(port_a_strong_sink_o),
  .port_a_analog_o(port_a_analog_o), .adc_enable_i(adc_enable_i),
  .adc_channel_select_i(adc_channel_select_i), .port_b_pin_o(port_b_pin_o),
  .port_c_pin_i(port_c_pin_i), .port_c_pin_oe_o(port_c_pin_oe_o),
  .spi_unit_enable_i(spi_unit_enable_i), .spi_oe_i(spi_oe_i),
  .second_external_interrupt_o(second_external_interrupt_o));
`default_nettype wire

// File: tb/tppio_pins.sv
// tppio_pins: the board around the block, resolving each pin level.
// assumes ext values model outside drivers and pull-up resistors.
`timescale 1ns/1ps
`default_nettype none
module tppio_pins (
  input  wire logic [7:0] a_o_i,
  input  wire logic [7:0] a_oe_i,
  input  wire logic [7:0] b_o_i,
  input  wire logic [7:0] b_oe_i,
  input  wire logic [7:0] c_o_i,
  input  wire logic [7:0] c_oe_i,
  input  wire logic [7:0] ext_a_i,
  input  wire logic [7:0] ext_b_i,
  input  wire logic [7:0] ext_c_i,
  output logic      [7:0] a_pin_o,
  output logic      [7:0] b_pin_o,
  output logic      [7:0] c_pin_o
);
  // driven bits win
  // a driven bit shows the device, a released one the outside world
  assign a_pin_o = (a_oe_i & a_o_i) | (~a_oe_i & ext_a_i);
  // pull-up on release
  // low nibble only ever pulled low; ext stands for the resistor level
  assign b_pin_o = (b_oe_i & b_o_i) | (~b_oe_i & ext_b_i);
  assign c_pin_o = (c_oe_i & c_o_i) | (~c_oe_i & ext_c_i);
endmodule : tppio_pins
`default_nettype wire

// File: tb/tppio_top_tb.sv
// tppio_top_tb: directed scenarios for the three-port i/o block.
// assumes the pin model tppio_pins and the bound checker tppio_sva.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module tppio_top_tb;
  import tppio_pkg::*;
  logic       clk, rst, wr, rd, adc_en, tw_en, sda_lo, sci_en, pu_dis, spi_en, ir_en, pu, irq;
  logic [7:0] addr, wd, rdat, els, ea, eb, ec, pa, pb, pc, ao, aoe, ask, aan, bo, boe, co, coe;
  logic [4:0] adc_sel;
  logic [3:0] t_out, t_oe, spi_out, spi_oe;
  logic       scl_lo, txd, irtx;
  logic [7:0] bsy, csy;
  int         bad_count, tests_run;
  int         cyc = 0;

  tppio_top i_tppio_top (.core_clk_i(clk), .rst_i(rst), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .port_a_pin_i(pa),
    .port_a_pin_o(ao), .port_a_pin_oe_o(aoe), .port_a_strong_sink_o(ask),
    .port_a_analog_o(aan), .port_b_pin_i(pb), .port_b_pin_o(bo), .port_b_pin_oe_o(boe),
    .port_c_pin_i(pc), .port_c_pin_o(co), .port_c_pin_oe_o(coe), .port_c0_pullup_en_o(pu),
    .adc_enable_i(adc_en), .adc_channel_select_i(adc_sel), .two_wire_module_enable_i(tw_en),
    .two_wire_sda_low_i(sda_lo), .two_wire_scl_low_i(scl_lo), .serial_unit_enable_i(sci_en),
    .serial_txd_i(txd), .timer_one_ch0_els_i(els[1:0]), .timer_one_ch1_els_i(els[3:2]),
    .timer_two_ch0_els_i(els[5:4]), .timer_two_ch1_els_i(els[7:6]), .timer_ch_out_i(t_out),
    .timer_ch_oe_i(t_oe), .port_c0_pullup_disable_i(pu_dis), .spi_unit_enable_i(spi_en),
    .spi_out_i(spi_out), .spi_oe_i(spi_oe), .infrared_serial_unit_enable_i(ir_en),
    .infrared_serial_transmit_i(irtx), .port_b_sync_o(bsy), .port_c_sync_o(csy),
    .second_external_interrupt_o(irq));
  tppio_pins i_tppio_pins (.a_o_i(ao), .a_oe_i(aoe), .b_o_i(bo), .b_oe_i(boe), .c_o_i(co),
    .c_oe_i(coe), .ext_a_i(ea), .ext_b_i(eb), .ext_c_i(ec), .a_pin_o(pa), .b_pin_o(pb),
    .c_pin_o(pc));

  // free-running system clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // one-cycle bus strobes; #1 lets the edge's updates land
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdat, e)
  endtask : rd_chk
  task automatic settle;
    repeat (6) @(posedge clk);
  endtask : settle

  // stimulus changes only on a rising edge, checks sit 1 ns after one, except the interrupt check right after a settle, which sits on the edge
  task automatic t_port_a;
    ea <= 8'hA5;
    wr_reg(OFF_PA_LATCH, 8'h5A);
    settle();
    rd_chk(OFF_PA_LATCH, 8'hA5);
    wr_reg(OFF_PA_DIR, 8'hF0);
    `CHK({ao, aoe}, 16'h5AF0)
    rd_chk(OFF_PA_LATCH, 8'h55);
    wr_reg(OFF_PA_LED, 8'h0F);
    `CHK(ask, 8'h00)
    rd_chk(OFF_PA_LED, 8'h0F);
    wr_reg(OFF_PA_DIR, 8'hFF);
    `CHK(ask, 8'h0F)
    @(posedge clk);
    adc_en <= 1'b1;
    adc_sel <= 5'h03;
    @(posedge clk);
    #1;
    `CHK({aan, aoe, ask}, 24'h08F707)
    @(posedge clk);
    adc_sel <= 5'h08;
    @(posedge clk);
    #1;
    `CHK(aan, 8'h00)
    @(posedge clk);
    adc_en <= 1'b0;
  endtask : t_port_a

  task automatic t_port_b;
    wr_reg(OFF_PB_LATCH, 8'hA5);
    wr_reg(OFF_PB_DIR, 8'hFF);
    `CHK({bo & boe, boe}, 16'hA0FA)
    rd_chk(OFF_PB_LATCH, 8'hA5);
    @(posedge clk);
    {tw_en, sda_lo, scl_lo, sci_en, txd} <= 5'h1F;
    els <= 8'h55;
    @(posedge clk);
    #1;
    `CHK({bo & boe, boe}, 16'h1013)
    @(posedge clk);
    {tw_en, sci_en, els} <= '0;
    eb <= 8'h3C;
    wr_reg(OFF_PB_DIR, 8'h00);
    settle();
    rd_chk(OFF_PB_LATCH, 8'h3C);
    `CHK(boe, 8'h00)
    `CHK(bsy, 8'h3C)
  endtask : t_port_b

  task automatic t_port_c;
    @(posedge clk);
    ec <= 8'h5A;
    wr_reg(OFF_PC_LATCH, 8'hC3);
    wr_reg(OFF_PC_DIR, 8'h0F);
    settle();
    rd_chk(OFF_PC_LATCH, 8'h53);
    `CHK(irq, 1'b1)
    `CHK(csy, 8'h53)
    wr_reg(OFF_PC_LATCH, 8'hC2);
    settle();
    `CHK(irq, 1'b0)
    @(posedge clk);
    {spi_en, ir_en, pu_dis, irtx} <= 4'hF;
    @(posedge clk);
    #1;
    `CHK({co & coe, coe, pu}, 17'h0ACAE)
    @(posedge clk);
    {spi_en, ir_en, pu_dis, irtx} <= 4'h0;
  endtask : t_port_c

  task automatic t_reset;
    wr_reg(8'h30, 8'hFF);
    rd_chk(8'h30, 8'h00);
    wr_reg(OFF_PB_DIR, 8'hFF);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    `CHK({aoe, boe, coe}, 24'h000000)
    rd_chk(OFF_PC_DIR, 8'h00);
    wr_reg(OFF_PA_DIR, 8'hFF);
    rd_chk(OFF_PA_LATCH, 8'h5A);
  endtask : t_reset

  task automatic end_sim;
    if (bad_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  // hang guard, far above the hundred or so cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      end_sim();
    end
  end

  initial begin
    {wr, rd, adc_en, tw_en, sda_lo, sci_en, pu_dis, spi_en, ir_en, bad_count, tests_run} = '0;
    {addr, wd, els, ea, adc_sel, scl_lo, txd, irtx} = '0;
    {spi_out, spi_oe, t_out, t_oe} = 16'hF531;
    {eb, ec} = 16'hFFFF;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_port_a();
    t_port_b();
    t_port_c();
    t_reset();
    end_sim();
  end
endmodule : tppio_top_tb
`default_nettype wire
